// [rtl/pma_reconfig_cfg.svh]
// constants of the analog-setting reconfiguration controller
`ifndef PMA_RECONFIG_CFG_SVH
`define PMA_RECONFIG_CFG_SVH
`define CHAN_NUM 4
`define BLK_NUM 1
`define STATUS_PER_BLK 5
`define CTRL_BUS_W 4
`define SWING_W 3
`define EMPH_W 5
`define DCGAIN_W 2
`define EQ_W 4
`define DIR_TX_ONLY 2'h2
`define DIR_RX_ONLY 2'h1
`define OFFSET_CANCEL_CYC 16
`define SER_LEN 16
`define CNT_W 5
`define ADDR_W 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_SWING 4'h2
`define REG_EMPH 4'h3
`define REG_DCGAIN 4'h4
`define REG_EQ 4'h5
`endif

// [rtl/pma_reconfig_pkg.sv]
// types of the analog-setting reconfiguration controller
package pma_reconfig_pkg;
    typedef enum logic [1:0] {
        ST_CANCEL = 2'b00,
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10,
        ST_DONE = 2'b11
    } ctl_state_e;
endpackage

// [rtl/pma_setting_store.sv]
// per-channel storage of the last written analog settings
`include "pma_reconfig_cfg.svh"
module pma_setting_store (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // write side
    input wire logic i_wr_tx,
    input wire logic i_wr_rx,
    input wire logic [`SWING_W-1:0] i_swing,
    input wire logic [`EMPH_W-1:0] i_emph,
    input wire logic [`DCGAIN_W-1:0] i_dcgain,
    input wire logic [`EQ_W-1:0] i_eq,
    // read side, one field per channel
    output logic [`SWING_W*`CHAN_NUM-1:0] o_swing,
    output logic [`EMPH_W*`CHAN_NUM-1:0] o_emph,
    output logic [`DCGAIN_W*`CHAN_NUM-1:0] o_dcgain,
    output logic [`EQ_W*`CHAN_NUM-1:0] o_eq
);
    genvar ch;
    // broadcast: each channel slot loads the same values
    generate
        for (ch = 0; ch < `CHAN_NUM; ch = ch + 1) begin : g_chan
            always_ff @(posedge i_clock or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_swing[ch*`SWING_W +: `SWING_W] <= '0;
                    o_emph[ch*`EMPH_W +: `EMPH_W] <= '0;
                    o_dcgain[ch*`DCGAIN_W +: `DCGAIN_W] <= '0;
                    o_eq[ch*`EQ_W +: `EQ_W] <= '0;
                end else begin
                    // transmit fields only when tx is selected
                    if (i_wr_tx) begin
                        o_swing[ch*`SWING_W +: `SWING_W] <= i_swing;
                        o_emph[ch*`EMPH_W +: `EMPH_W] <= i_emph;
                    end
                    // receive fields stay untouched for tx-only writes
                    if (i_wr_rx) begin
                        o_dcgain[ch*`DCGAIN_W +: `DCGAIN_W] <= i_dcgain;
                        o_eq[ch*`EQ_W +: `EQ_W] <= i_eq;
                    end
                end
            end
        end
    endgenerate
endmodule // pma_setting_store

// [rtl/pma_reconfig_ctrl.sv]
// analog-setting reconfiguration controller with broadcast write
// Functional notes
// - status bus five bits per block
// - one four-bit control bus to all
// - read-back widths per channel times channels
// - broadcast write reaches every channel
// - direction 2'b10 writes transmit settings only
// - busy high during transfer, low after
// - offset cancellation takes 16 cycles
//
// The register addresses and strobed register access are this design's own decisions.
`include "pma_reconfig_cfg.svh"
module pma_reconfig_ctrl (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // write request from user logic
    input wire logic i_write_all,
    input wire logic [1:0] i_dir_sel,
    input wire logic [`SWING_W-1:0] i_swing,
    input wire logic [`EMPH_W-1:0] i_emph,
    input wire logic [`DCGAIN_W-1:0] i_dcgain,
    input wire logic [`EQ_W-1:0] i_eq,
    // software register port
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // transceiver side
    input wire logic [`STATUS_PER_BLK*`BLK_NUM-1:0] i_from_xcvr,
    output logic [`CTRL_BUS_W-1:0] o_to_xcvr,
    // status to user logic
    output logic o_busy,
    output logic [`SWING_W*`CHAN_NUM-1:0] o_swing,
    output logic [`EMPH_W*`CHAN_NUM-1:0] o_emph,
    output logic [`DCGAIN_W*`CHAN_NUM-1:0] o_dcgain,
    output logic [`EQ_W*`CHAN_NUM-1:0] o_eq
);
    localparam int unsigned SW = `STATUS_PER_BLK*`BLK_NUM;
    localparam int CANCEL_LAST = `OFFSET_CANCEL_CYC - 1;
    localparam int SER_LAST = `SER_LEN - 1;

    // controller state
    pma_reconfig_pkg::ctl_state_e state_ff, nxt_state;
    logic [`CNT_W-1:0] cnt_ff; // cycle counter within a phase
    logic [`CNT_W-1:0] nxt_cnt;
    logic [`SER_LEN-1:0] shift_ff; // serial frame to channels
    logic [`SER_LEN-1:0] nxt_shift;
    logic [1:0] dir_ff; // direction latched at start
    logic [`CNT_W-1:0] wr_count_ff; // completed writes, wraps
    logic sw_start_ff; // software-requested write pulse
    logic sw_txonly_ff; // software forces transmit-only writes
    // status bus sync stages: first stage feeds only the second
    logic [SW-1:0] stat_meta_ff;
    logic [SW-1:0] stat_sync_ff;
    logic busy_q_ff; // busy mirror for o_busy
    logic [`CTRL_BUS_W-1:0] to_xcvr_ff;

    // decode of the request and write enables
    wire any_start = i_write_all | sw_start_ff;
    wire idle = (state_ff == pma_reconfig_pkg::ST_IDLE);
    wire take = any_start & idle;
    wire [1:0] eff_dir = sw_txonly_ff ? `DIR_TX_ONLY : i_dir_sel;
    wire cancel_end = (state_ff == pma_reconfig_pkg::ST_CANCEL) &&
        (cnt_ff == CANCEL_LAST[`CNT_W-1:0]);
    wire send_end = (state_ff == pma_reconfig_pkg::ST_SEND) &&
        (cnt_ff == SER_LAST[`CNT_W-1:0]);
    wire done = (state_ff == pma_reconfig_pkg::ST_DONE);
    wire wr_tx = done && (dir_ff != `DIR_RX_ONLY);
    wire wr_rx = done && (dir_ff != `DIR_TX_ONLY);
    wire [`SER_LEN-1:0] frame = {eff_dir, i_eq, i_dcgain, i_emph,
        i_swing};
    wire rd_ctrl = (i_addr == `REG_CTRL);
    wire rd_stat = (i_addr == `REG_STATUS);
    wire rd_sw = (i_addr == `REG_SWING);
    wire rd_em = (i_addr == `REG_EMPH);
    wire rd_dc = (i_addr == `REG_DCGAIN);
    wire rd_eq = (i_addr == `REG_EQ);
    wire [31:0] rd_val =
        rd_ctrl ? {31'h0, sw_txonly_ff} :
        rd_stat ? {{(32-`CNT_W-SW-1){1'b0}}, wr_count_ff,
                   stat_sync_ff, busy_q_ff} :
        rd_sw ? {{(32-`SWING_W*`CHAN_NUM){1'b0}}, o_swing} :
        rd_em ? {{(32-`EMPH_W*`CHAN_NUM){1'b0}}, o_emph} :
        rd_dc ? {{(32-`DCGAIN_W*`CHAN_NUM){1'b0}}, o_dcgain} :
        rd_eq ? {{(32-`EQ_W*`CHAN_NUM){1'b0}}, o_eq} : 32'h0;

    // next state: cancel after reset, idle, shift out, commit
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 5'h01;
        nxt_shift = shift_ff;
        unique case (state_ff)
            pma_reconfig_pkg::ST_CANCEL: begin
                if (cancel_end) begin
                    nxt_state = pma_reconfig_pkg::ST_IDLE;
                    nxt_cnt = 5'h00;
                end
            end
            pma_reconfig_pkg::ST_IDLE: begin
                nxt_cnt = 5'h00;
                if (take) begin
                    nxt_state = pma_reconfig_pkg::ST_SEND;
                    nxt_shift = frame;
                end
            end
            pma_reconfig_pkg::ST_SEND: begin
                // nibble-serial transfer, four bits per cycle
                nxt_shift = {4'h0, shift_ff[`SER_LEN-1:4]};
                if (send_end) begin
                    nxt_state = pma_reconfig_pkg::ST_DONE;
                    nxt_cnt = 5'h00;
                end
            end
            pma_reconfig_pkg::ST_DONE: begin
                nxt_state = pma_reconfig_pkg::ST_IDLE;
                nxt_cnt = 5'h00;
            end
        endcase
    end

    // state registers
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= pma_reconfig_pkg::ST_CANCEL;
            cnt_ff <= 5'h00;
            shift_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
        end
    end

    // direction and write counter
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dir_ff <= 2'h0;
            wr_count_ff <= 5'h00;
        end else begin
            if (take) dir_ff <= eff_dir;
            if (done) wr_count_ff <= wr_count_ff + 5'h01;
        end
    end

    // busy covers cancellation and every transfer
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_q_ff <= 1'b1;
        end else begin
            busy_q_ff <= ~((idle & ~take) | done);
        end
    end
    assign o_busy = busy_q_ff;

    // control bus: one nibble bus drives all groups
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            to_xcvr_ff <= 4'h0;
        end else begin
            to_xcvr_ff <= (state_ff == pma_reconfig_pkg::ST_SEND) ?
                shift_ff[3:0] : 4'h0;
        end
    end
    assign o_to_xcvr = to_xcvr_ff;

    // status bus synchroniser
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stat_meta_ff <= '0;
            stat_sync_ff <= '0;
        end else begin
            stat_meta_ff <= i_from_xcvr;
            stat_sync_ff <= stat_meta_ff;
        end
    end

    // register port: write decode and read data
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sw_start_ff <= 1'b0;
            sw_txonly_ff <= 1'b0;
            o_rdata <= 32'h0;
        end else begin
            sw_start_ff <= i_wr && rd_ctrl && i_wdata[1];
            if (i_wr && rd_ctrl) sw_txonly_ff <= i_wdata[0];
            o_rdata <= i_rd ? rd_val : 32'h0;
        end
    end

    // settings seen by every channel
    // broadcast store
    pma_setting_store u_store (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_wr_tx(wr_tx),
        .i_wr_rx(wr_rx),
        .i_swing(i_swing),
        .i_emph(i_emph),
        .i_dcgain(i_dcgain),
        .i_eq(i_eq),
        .o_swing(o_swing),
        .o_emph(o_emph),
        .o_dcgain(o_dcgain),
        .o_eq(o_eq)
    );

    // checks
    // busy spans all sixteen cancel cycles plus the hand-over edge
    property p_cancel_len;
        @(posedge i_clock) disable iff (!i_rst_b)
        $rose(i_rst_b) |-> o_busy [*8] ##1 o_busy [*8] ##1 o_busy
            ##1 !o_busy;
    endproperty
    a_cancel_len: assert property (p_cancel_len)
        else $error("busy not held through cancellation");

    // a restart would reload the frame instead of shifting it on
    property p_ignore;
        @(posedge i_clock) disable iff (!i_rst_b)
        (state_ff == pma_reconfig_pkg::ST_SEND) && any_start
        |=> shift_ff == ($past(shift_ff) >> 4);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("strobe disturbed a transfer");

    property p_busy_span;
        @(posedge i_clock) disable iff (!i_rst_b)
        take |=> o_busy [*8];
    endproperty
    a_busy_span: assert property (p_busy_span)
        else $error("busy not held during transfer");

    property p_busy_end;
        @(posedge i_clock) disable iff (!i_rst_b)
        done |=> !o_busy;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy not released after write");

    property p_done_time;
        @(posedge i_clock) disable iff (!i_rst_b)
        take |-> ##17 done;
    endproperty
    a_done_time: assert property (p_done_time)
        else $error("write did not finish in time");

    property p_txonly;
        @(posedge i_clock) disable iff (!i_rst_b)
        done && dir_ff == `DIR_TX_ONLY |=> $stable(o_eq) &&
            $stable(o_dcgain);
    endproperty
    a_txonly: assert property (p_txonly)
        else $error("receive settings changed on tx-only write");

    property p_bcast;
        @(posedge i_clock) disable iff (!i_rst_b)
        wr_tx |=> o_swing == {`CHAN_NUM{$past(i_swing)}} &&
            o_emph == {`CHAN_NUM{$past(i_emph)}};
    endproperty
    a_bcast: assert property (p_bcast)
        else $error("channels disagree after broadcast");

    property p_bus_idle;
        @(posedge i_clock) disable iff (!i_rst_b)
        idle && $past(idle) |-> o_to_xcvr == 4'h0;
    endproperty
    a_bus_idle: assert property (p_bus_idle)
        else $error("control bus active while idle");

    property p_sync;
        @(posedge i_clock) disable iff (!i_rst_b)
        ##2 1'b1 |-> stat_sync_ff == $past(i_from_xcvr, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("status bus not two-stage synchronised");
endmodule // pma_reconfig_ctrl

// [bench/xcvr_status_model.sv]
// stand-in for the one transceiver block behind the controller
module xcvr_status_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // control bus in, status bus out
    input wire logic [3:0] i_to_xcvr,
    output logic [4:0] o_from_xcvr
);
    timeunit 1ns;
    timeprecision 1ns;
    // status echoes the control bus, so an idle bus reads back 5'h15
    // one block, low slice
    // no power-down here, block stays up
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_from_xcvr <= 5'h00;
        end else begin
            // alternating bits so a swapped status slice shows
            o_from_xcvr <= {1'b1, i_to_xcvr ^ 4'h5};
        end
    end
endmodule // xcvr_status_model

// [bench/tb_top.sv]
// self-checking bench of the reconfiguration controller
`include "pma_reconfig_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic wr_all = 1'b0;
    logic [1:0] dir = 2'h0;
    logic [2:0] sw = 3'h0;
    logic [4:0] em = 5'h00;
    logic [1:0] dc = 2'h0;
    logic [3:0] eq = 4'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [4:0] stat;
    logic [3:0] ctl;
    logic busy;
    logic [11:0] o_sw;
    logic [19:0] o_em;
    logic [7:0] o_dc;
    logic [15:0] o_eq;
    int err_count = 0;
    int comparisons = 0;
    // 200 MHz clock; rate limits only matter for real timing
    // free-running clock
    always #2.5 i_clock = ~i_clock;
    pma_reconfig_ctrl i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_write_all(wr_all), .i_dir_sel(dir), .i_swing(sw),
        .i_emph(em), .i_dcgain(dc), .i_eq(eq), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_from_xcvr(stat), .o_to_xcvr(ctl), .o_busy(busy),
        .o_swing(o_sw), .o_emph(o_em), .o_dcgain(o_dc), .o_eq(o_eq));
    xcvr_status_model i_xcvr (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_to_xcvr(ctl), .o_from_xcvr(stat));
    task automatic end_of_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // read-back outputs hold one copy per channel
    task automatic chk_out(input logic [2:0] s, input logic [4:0] e,
                           input logic [1:0] g, input logic [3:0] q);
        check("swing", 32'(o_sw), 32'({4{s}}));
        check("emph", 32'(o_em), 32'({4{e}}));
        check("dcgain", 32'(o_dc), 32'({4{g}}));
        check("eq", 32'(o_eq), 32'({4{q}}));
    endtask
    // register port: one-cycle strobes, read data one cycle later
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // values first, then one strobe; optional second strobe mid-write
    task automatic put(input logic [1:0] d, input logic [2:0] s,
                       input logic [4:0] e, input logic [1:0] g,
                       input logic [3:0] q, input bit again);
        logic [15:0] fr;
        @(posedge i_clock);
        dir <= d;
        sw <= s;
        em <= e;
        dc <= g;
        eq <= q;
        @(posedge i_clock);
        wr_all <= 1'b1;
        @(posedge i_clock);
        wr_all <= 1'b0;
        #1 check("busy rise", 32'(busy), 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clock);
            if (again) begin
                wr_all <= (i == 1);
            end
            #1 fr[i*4+:4] = ctl;
        end
        check("frame", 32'(fr), 32'({d, q, g, e, s}));
        repeat (12) @(posedge i_clock);
        #1 check("busy held", 32'(busy), 32'h1);
        @(posedge i_clock);
        #1 check("busy fall", 32'(busy), 32'h0);
        @(posedge i_clock);
        #1 check("no restart", 32'(busy), 32'h0);
    endtask
    // hang guard, far beyond the roughly 140 cycles of the tests
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
    initial begin
        logic [31:0] v;
        repeat (5) @(posedge i_clock);
        #1 check("busy in reset", 32'(busy), 32'h1);
        @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (16) @(posedge i_clock);
        #1 check("cancel busy", 32'(busy), 32'h1);
        repeat (2) @(posedge i_clock);
        #1 check("cancel done", 32'(busy), 32'h0);
        put(2'h0, 3'h1, 5'h13, 2'h2, 4'h9, 1'b0);
        chk_out(3'h1, 5'h13, 2'h2, 4'h9);
        put(2'h2, 3'h5, 5'h0c, 2'h1, 4'h6, 1'b1);
        chk_out(3'h5, 5'h0c, 2'h2, 4'h9);
        put(2'h1, 3'h2, 5'h1f, 2'h3, 4'hf, 1'b0);
        chk_out(3'h5, 5'h0c, 2'h3, 4'hf);
        put(2'h3, 3'h7, 5'h01, 2'h0, 4'h3, 1'b0);
        chk_out(3'h7, 5'h01, 2'h0, 4'h3);
        reg_rd(`REG_SWING, v);
        check("rd swing", v, 32'h00000fff);
        @(posedge i_clock);
        #1 check("rd idle", rdata, 32'h0);
        reg_rd(`REG_STATUS, v);
        check("rd status", v, {21'h0, 5'd4, 5'h15, 1'b0});
        reg_rd(4'h9, v);
        check("rd unmapped", v, 32'h0);
        reg_wr(`REG_EQ, 32'hffffffff);
        reg_rd(`REG_EQ, v);
        check("rd eq", v, 32'h00003333);
        // software start with tx-only forced
        @(posedge i_clock);
        sw <= 3'h4;
        eq <= 4'ha;
        reg_wr(`REG_CTRL, 32'h3);
        // start pulse is registered, busy follows one edge later
        @(posedge i_clock);
        #1 check("sw busy", 32'(busy), 32'h1);
        for (int n = 0; n < 40 && busy !== 1'b0; n++) begin
            @(posedge i_clock);
            #1;
        end
        check("sw done", 32'(busy), 32'h0);
        chk_out(3'h4, 5'h01, 2'h0, 4'h3);
        end_of_test();
    end
endmodule // tb_top
